// file: hdl/psc_defines.svh
// Constants for the port sideband control block.
// Assumes a single 10 MHz core clock and a synchronous active-high reset.
// Notes on behaviour
// [RULE_01] Power enable low means port power on.
// [RULE_02] Overcurrent inputs are active low.
// [RULE_03] Indicator outputs drive high when active.
// [RULE_04] Indicator pins double as flash pins.
// [RULE_05] Port one/two overcurrent pins double as debug pair.
// [RULE_06] Test select low normal, high test.
// [RULE_07] Upstream plug detect recognises upstream attach.
// [RULE_08] Bus power input means 5 V present.
// [RULE_09] Two special pins stay reserved.
// [RULE_10] Flash role only during a flash access.
// [RULE_11] Asynchronous inputs pass two flip-flops first.
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH
`define PSC_PORTS        4
`define PSC_PWR_ON       1'b0
`define PSC_PWR_OFF      1'b1
`define PSC_OC_ACTIVE    1'b0
`define PSC_IND_ON       1'b1
`define PSC_FL_DIN       0
`define PSC_FL_SCLK      1
`define PSC_FL_DOUT      2
`define PSC_FL_SEL_N     3
`define PSC_DBG_DATA     0
`define PSC_DBG_CLK      1
`define PSC_VB_PLUG      0
`define PSC_VB_BUS       1
`define PSC_TM_PIN       1
`define PSC_DBG_LEVEL    2'h0
`endif

// file: hdl/psc_pkg.sv
// Types shared by the port sideband control block.
// Assumes the constants header is included beside it.
`include "psc_defines.svh"
package psc_pkg;
  typedef enum logic [0:0] {
    PSC_IND  = 1'b0,
    PSC_FLASH = 1'b1
  } psc_role_type;

  typedef struct packed {
    logic [`PSC_PORTS-1:0] oc_meta;
    logic [`PSC_PORTS-1:0] oc_sync;
    logic [1:0]            vb_meta;
    logic [1:0]            vb_sync;
    logic [1:0]            tm_meta;
    logic [1:0]            tm_sync;
    logic                  up_oc_meta;
    logic                  up_oc_sync;
    psc_role_type          role;
    logic [`PSC_PORTS-1:0] power_n;
    logic [`PSC_PORTS-1:0] pins;
    logic [`PSC_PORTS-1:0] oc_flag;
    logic                  up_oc;
    logic                  attached;
    logic                  bus_ok;
    logic                  test_mode;
    logic [1:0]            dbg_oe;
    logic [1:0]            spec_oe;
    logic [1:0]            dbg_out;
    logic                  fd_meta;
    logic                  fd_sync;
    logic                  fd_sample;
  } psc_state_type;
endpackage

// file: hdl/psc_sideband.sv
// Sideband pins of a four-port hub: power enables, overcurrent, indicators,
// flash sharing, debug pair, plug and bus power detect, test select.
// Assumes control inputs come from core logic on core_clk; pins are asynchronous.
`timescale 1ns/1ps
`include "psc_defines.svh"
module psc_sideband
  import psc_pkg::*;
#(
  parameter int PORTS = `PSC_PORTS
)(
  input  wire logic             core_clk,           // Core clock, 10 MHz.
  input  wire logic             rst,                // Synchronous reset, active high.
  input  wire logic [PORTS-1:0] port_power_req,     // Core asks port power on.
  input  wire logic [PORTS-1:0] port_indicator_req, // Core asks indicator lit.
  input  wire logic             flash_busy,         // Flash access in progress.
  input  wire logic             flash_serial_clock_in, // Flash clock from core.
  input  wire logic             flash_data_out_in,  // Flash data to device pin.
  input  wire logic             flash_select_n_in,  // Flash select from core.
  input  wire logic             flash_data_in,      // Flash data-in pin sample.
  input  wire logic [PORTS-1:0] port_overcurrent_n, // Overcurrent pins, active low.
  input  wire logic             upstream_overcurrent_n, // Upstream overcurrent pin.
  input  wire logic [1:0]       debug_drive_low,    // Core pulls debug pair low.
  input  wire logic             upstream_plug_detect, // Upstream VBUS pin.
  input  wire logic             bus_power_present,  // 5 V bus presence pin.
  input  wire logic             test_mode_select,   // Test select pin.
  input  wire logic [1:0]       special_pin_in,     // Reserved special pins, input.
  output logic [PORTS-1:0]      port_power_on_n,    // Power enables, active low.
  output logic [PORTS-1:0]      port_indicator,     // Indicator or flash pins.
  output logic [1:0]            debug_serial_oe,    // Debug pair pull-low enable.
  output logic [1:0]            debug_serial_out,   // Debug pair output level.
  output logic [1:0]            debug_serial_in,    // Debug pair, synchronised.
  output logic [PORTS-1:0]      port_overcurrent,   // Overcurrent flags, active high.
  output logic                  upstream_overcurrent, // Upstream overcurrent flag.
  output logic                  upstream_attached,  // Upstream plug seen.
  output logic                  bus_power_ok,       // Bus supply present.
  output logic                  test_mode,          // Test mode active.
  output logic [1:0]            special_pin_oe,     // Reserved pins never driven.
  output logic                  flash_sample        // Flash data-in, synchronised.
);
  // Value of every state field while rst is high. Port power stays off and the
  // overcurrent synchronisers rest at the pins' idle high level, so the end of
  // reset never reports a false overload.
  localparam psc_state_type reset_state = '{
    oc_meta:    {`PSC_PORTS{~`PSC_OC_ACTIVE}},
    oc_sync:    {`PSC_PORTS{~`PSC_OC_ACTIVE}},
    vb_meta:    2'h0,
    vb_sync:    2'h0,
    tm_meta:    2'h0,
    tm_sync:    2'h0,
    up_oc_meta: ~`PSC_OC_ACTIVE,
    up_oc_sync: ~`PSC_OC_ACTIVE,
    role:       PSC_IND,
    power_n:    {`PSC_PORTS{`PSC_PWR_OFF}},
    pins:       {`PSC_PORTS{~`PSC_IND_ON}},
    oc_flag:    {`PSC_PORTS{1'b0}},
    up_oc:      1'b0,
    attached:   1'b0,
    bus_ok:     1'b0,
    test_mode:  1'b0,
    dbg_oe:     2'h0,
    spec_oe:    2'h0,
    dbg_out:    `PSC_DBG_LEVEL,
    fd_meta:    1'b0,
    fd_sync:    1'b0,
    fd_sample:  1'b0
  };

  psc_state_type r;
  psc_state_type next_r;

  // Turns a synchronised active-low pin level into an active-high flag.
  function automatic logic psc_pin_flag(input logic level_n);
    psc_pin_flag = (level_n == `PSC_OC_ACTIVE);
  endfunction

  always_comb
  begin
    next_r = r;
    // [RULE_11] Two-stage synchronisers.
    next_r.oc_meta                = port_overcurrent_n;
    next_r.oc_sync                = r.oc_meta;
    next_r.vb_meta[`PSC_VB_PLUG]  = upstream_plug_detect;
    next_r.vb_meta[`PSC_VB_BUS]   = bus_power_present;
    next_r.vb_sync                = r.vb_meta;
    next_r.tm_meta                = 2'h0;
    next_r.tm_meta[`PSC_TM_PIN]   = test_mode_select;
    next_r.tm_sync                = r.tm_meta;
    next_r.up_oc_meta             = upstream_overcurrent_n;
    next_r.up_oc_sync             = r.up_oc_meta;
    next_r.fd_meta                = flash_data_in;
    next_r.fd_sync                = r.fd_meta;
    next_r.fd_sample              = r.fd_sync;
    // [RULE_02] Low means overcurrent.
    for (int i = 0; i < PORTS; i++)
    begin
      next_r.oc_flag[i] = psc_pin_flag(r.oc_sync[i]);
    end
    next_r.up_oc = psc_pin_flag(r.up_oc_sync);
    // [RULE_01] Drive low for power on.
    for (int i = 0; i < PORTS; i++)
    begin
      next_r.power_n[i] = port_power_req[i] ? `PSC_PWR_ON : `PSC_PWR_OFF;
    end
    // [RULE_10] Flash role during access only.
    next_r.role = flash_busy ? PSC_FLASH : PSC_IND;
    // [RULE_04] Shared indicator and flash pins.
    // The mux follows the registered role, so a role change reaches the pins
    // two cycles after flash_busy moves, one later than the pin data, and all four pins switch together.
    case (r.role)
      PSC_FLASH:
      begin
        // The data-in pin is read back from the flash, so it is held low here.
        next_r.pins                = '0;
        next_r.pins[`PSC_FL_SCLK]  = flash_serial_clock_in;
        next_r.pins[`PSC_FL_DOUT]  = flash_data_out_in;
        next_r.pins[`PSC_FL_SEL_N] = flash_select_n_in;
      end
      PSC_IND:
      begin
        // [RULE_03] Indicator high when active.
        for (int i = 0; i < PORTS; i++)
        begin
          next_r.pins[i] = port_indicator_req[i] ? `PSC_IND_ON : ~`PSC_IND_ON;
        end
      end
      default:
      begin
        next_r.pins = '0;
      end
    endcase
    // [RULE_05] Open-drain debug pair.
    next_r.dbg_oe    = debug_drive_low;
    next_r.dbg_out   = `PSC_DBG_LEVEL;
    // [RULE_07] Upstream attach from VBUS.
    next_r.attached  = r.vb_sync[`PSC_VB_PLUG];
    // [RULE_08] Bus supply presence.
    next_r.bus_ok    = r.vb_sync[`PSC_VB_BUS];
    // [RULE_06] High selects test mode.
    next_r.test_mode = r.tm_sync[`PSC_TM_PIN];
    // [RULE_09] Special pins kept undriven.
    next_r.spec_oe   = 2'h0;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      r <= reset_state;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign port_power_on_n      = r.power_n;
  assign port_indicator       = r.pins;
  assign debug_serial_oe      = r.dbg_oe;
  assign debug_serial_out     = r.dbg_out;
  assign debug_serial_in      = {r.oc_sync[`PSC_DBG_CLK], r.oc_sync[`PSC_DBG_DATA]};
  assign flash_sample         = r.fd_sample;
  assign port_overcurrent     = r.oc_flag;
  assign upstream_overcurrent = r.up_oc;
  assign upstream_attached    = r.attached;
  assign bus_power_ok         = r.bus_ok;
  assign test_mode            = r.test_mode;
  assign special_pin_oe       = r.spec_oe;
endmodule

// file: verif/psc_board.sv
// Board model: port switches, debug pull-ups and a flash part.
// Assumes the bench injects overloads.
`timescale 1ns/1ps
module psc_board (
  input  wire logic [3:0] power_on_n, // Switch enables.
  input  wire logic [3:0] fault,      // Overloads.
  input  wire logic [1:0] dbg_oe,     // Debug pull-low.
  input  wire logic [3:0] led,        // Indicator pins.
  output logic [3:0]      oc_n,       // Overcurrent pins.
  output logic            flash_out   // Flash data.
);
  // Overloads on powered ports, debug pull-ups.
  assign oc_n = ~(fault & ~power_on_n) & {2'h3, ~dbg_oe};
  assign flash_out = !led[3] & led[2];
endmodule

// file: verif/psc_sideband_assertions.sv
// Timing checker of the sideband pins.
// Assumes a bind onto psc_sideband.
`timescale 1ns/1ps
module psc_chk (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [3:0] port_power_req,
  input wire logic [3:0] port_power_on_n,
  input wire logic       flash_busy,
  input wire logic [3:0] port_indicator,
  input wire logic [1:0] debug_drive_low,
  input wire logic [1:0] debug_serial_oe,
  input wire logic [1:0] debug_serial_out,
  input wire logic [1:0] special_pin_oe,
  input wire logic [3:0] port_overcurrent_n,
  input wire logic [1:0] debug_serial_in
);
  logic [1:0] up;
  always_ff @(posedge core_clk) up <= rst ? 2'h0 : up + 2'(up != 2'h3);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence warm; up == 2'h3; endsequence
  pwr_on_a: assert property ($rose(port_power_req[0]) |=> !port_power_on_n[0])
    else $error("power on late");
  pwr_off_a: assert property ($fell(port_power_req[3]) |=> port_power_on_n[3])
    else $error("power off late");
  pwr_hold_a: assert property (
    warm ##0 $stable(port_power_req) [*2] |-> $stable(port_power_on_n)) else $error("power moved");
  flash_bit0_a: assert property (
    warm ##0 $past(flash_busy, 2) |-> !port_indicator[0]) else $error("flash pin0 high");
  dbg_oe_a: assert property (
    warm |-> debug_serial_oe == $past(debug_drive_low)) else $error("debug enable");
  dbg_in_a: assert property (
    warm |-> debug_serial_in == $past(port_overcurrent_n[1:0], 2)) else $error("debug input");
  dbg_out_a: assert property (debug_serial_out == 2'h0)
    else $error("debug level");
  spec_oe_a: assert property (special_pin_oe == 2'h0)
    else $error("special pin driven");
endmodule
bind psc_sideband psc_chk i_psc_chk (.core_clk, .rst, .port_power_req, .port_power_on_n,
  .flash_busy, .port_indicator, .debug_drive_low, .debug_serial_oe, .debug_serial_out,
  .special_pin_oe, .port_overcurrent_n, .debug_serial_in);

// file: verif/psc_sideband_tb_top.sv
// Random and corner traffic on the sideband block with a board model.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
module psc_sideband_tb_top;
  logic             core_clk = 1'b0;
  logic             rst = 1'b1;
  logic [31:0]      r = '0;
  logic [2:0][31:0] h;
  logic [2:0][4:0]  o;
  logic [3:0]       pw_n, ind, oc, oc_n, st;
  logic [1:0]       oe;
  logic             fdi, fs;
  int               seed = 52378, n_mismatch = 0, comparisons = 0;
  always #50 core_clk = ~core_clk;
  psc_sideband i_psc_sideband (.core_clk, .rst, .port_power_req(r[3:0]),
    .port_indicator_req(r[7:4]), .flash_busy(r[8]), .flash_serial_clock_in(r[9]),
    .flash_data_out_in(r[10]), .flash_select_n_in(r[11]), .flash_data_in(fdi),
    .port_overcurrent_n(oc_n), .upstream_overcurrent_n(r[19]), .debug_drive_low(r[13:12]),
    .upstream_plug_detect(r[14]), .bus_power_present(r[15]), .test_mode_select(r[16]),
    .special_pin_in(r[18:17]), .port_power_on_n(pw_n), .port_indicator(ind),
    .debug_serial_oe(oe), .debug_serial_out(), .debug_serial_in(), .port_overcurrent(oc),
    .upstream_overcurrent(st[0]), .upstream_attached(st[1]), .bus_power_ok(st[2]),
    .test_mode(st[3]), .special_pin_oe(), .flash_sample(fs));
  psc_board i_psc_board (.power_on_n(pw_n), .fault(r[23:20]), .dbg_oe(oe), .led(ind),
    .oc_n, .flash_out(fdi));
  function automatic logic [3:0] exp_ind(input logic busy, input logic [31:0] v);
    exp_ind = busy ? {v[11:9], 1'b0} : v[7:4];
  endfunction
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // The first four cycles hold every bit of r low, the next four high.
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 400; i++)
    begin
      @(posedge core_clk);
      h = {h[1:0], r};
      o = {o[1:0], {fdi, oc_n}};
      r <= (i < 8) ? {32{i[2]}} : $random(seed);
      @(negedge core_clk);
      if (i > 3)
      begin
        chk(pw_n, ~h[0][3:0]);
        chk(ind, exp_ind(h[1][8], h[0]));
        chk(oc, ~o[2][3:0]);
        chk({3'h0, fs}, {3'h0, o[2][4]});
        chk(st, {h[2][16:14], ~h[2][19]});
      end
    end
    print_verdict;
  end
  initial
  begin
    #(100 * 500);
    n_mismatch++;
    print_verdict;
  end
endmodule
